// file: shared/flpc_pkg.sv
// Package: constants, types and timing for the forward link pulse interval codec
package flpc_pkg;
  // Clock and symbol timing
  localparam int CLK_HZ            = 40_000_000;
  localparam int TARI_NS           = 20_000;        // Reference interval in ns
  localparam int CLK_NS            = 25;
  localparam int TARI_CYC          = TARI_NS / CLK_NS;
  localparam int CNT_W             = 16;
  // Identifier layout
  localparam int UID_W             = 64;
  localparam int SHORT_ID_W        = 40;
  localparam int MAKER_W           = 8;
  localparam int SERIAL_W          = 32;
  localparam int PAD_W             = 16;
  localparam logic [7:0] ALLOC_PREFIX = 8'h5a;      // Arbitrary neutral value
  localparam logic [PAD_W-1:0] PAD_ZERO = 16'h0000;
  localparam int FIFO_DEPTH        = 16;
  // Symbol geometry, in reference units or half units
  localparam int SOF_CAL_UNITS     = 3;   // Calibration tail of start-of-frame
  localparam int SOF_LIMIT_UNITS   = 8;   // Give up on an unfinished start-of-frame
  localparam int ZERO_LO_HALVES    = 1;   // Zero must exceed half a unit
  localparam int ONE_LO_HALVES     = 3;   // Zero/one split point
  localparam int ONE_HI_HALVES     = 5;   // One must not exceed this
  localparam int EOF_HALVES        = 8;   // Silence that ends a frame

  typedef enum logic [1:0] {
    FLPC_READY = 2'b00,  // Waiting for start-of-frame
    FLPC_CAL   = 2'b01,  // Measuring the three-unit calibration interval
    FLPC_DATA  = 2'b10,  // Decoding data symbols
    FLPC_QUIET = 2'b11   // Error: waiting for quiet carrier
  } flpc_state_t;

  typedef struct packed {
    logic bit_val;
    logic frame_end;
  } flpc_sym_t;
endpackage

// file: design/flpc_codec.sv
// Forward link pulse interval decoder with symbol FIFO and identifier formatting
// Functional notes
// - Time symbols between falling carrier edges
// - Decode zero and one by interval windows
// - Threshold equals 3/2 measured reference unit
// - Gap over four units ends frame cleanly
// - Long silence returns decoder to ready
// - Invalid code drops frame until quiet
// - Bits are assembled most significant first
// - Identifier holds prefix, maker, zeros, serial
// - Identifier fixed at manufacture, not writable
// - Short identifier is maker plus serial
// - Sixteen zero pad bits dropped in short form
// - Arbitration replies use short identifier
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Symbol FIFO
// ----------------------------------------------------------------
module flpc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  // Pointers with wrap bit give honest full and empty
  always_comb begin
    in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    out_valid = wr_reg != rd_reg;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_next   = push ? wr_reg + 1'b1 : wr_reg;
    rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
    out_data  = mem[rd_reg[AW-1:0]];
  end

  // Storage has no reset: only words behind the write pointer are ever read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// Codec top
// ----------------------------------------------------------------
module flpc_codec import flpc_pkg::*; #(
  parameter int                 CNT_WIDTH  = CNT_W,
  parameter int                 DEPTH      = FIFO_DEPTH,
  parameter logic [MAKER_W-1:0] MAKER_CODE = 8'h11,      // Arbitrary neutral value
  parameter logic [SERIAL_W-1:0] SERIAL    = 32'h0000_0001 // Arbitrary neutral value
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  carrier_in,
  output logic                       bit_valid,
  output logic                       bit_data,
  input  wire logic                  bit_ready,
  output logic                       frame_done,
  output logic                       frame_error,
  output logic                       sym_overflow,
  output logic                       decoder_ready,
  input  wire logic                  full_id_sel,
  output logic [UID_W-1:0]           unique_identifier,
  output logic [SHORT_ID_W-1:0]      short_tag_id,
  output logic [UID_W-1:0]           reply_id
);
  // Longest count the decoder must hold is the start-of-frame limit
  localparam int SOF_LIMIT = SOF_LIMIT_UNITS * TARI_CYC;
  // Short replies are zero-extended to the full identifier width
  localparam int ID_PAD_W  = UID_W - SHORT_ID_W;

  initial begin
    if (CNT_WIDTH < $clog2(SOF_LIMIT)) $error("CNT_WIDTH too small for timing");
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end

  // ----------------------------------------------------------------
  // Falling edge timing
  // ----------------------------------------------------------------
  logic                 prev_reg;
  logic                 prev_next;
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] cnt_next;
  logic [CNT_WIDTH-1:0] tari_reg;      // Measured reference unit
  logic [CNT_WIDTH-1:0] tari_next;
  logic                 fall;          // One-cycle falling edge mark
  flpc_state_t          st_reg;
  flpc_state_t          st_next;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_pop;
  flpc_sym_t            fifo_in;
  flpc_sym_t            fifo_out;
  logic                 done_reg;
  logic                 done_next;
  logic                 err_reg;
  logic                 err_next;
  logic                 ovf_reg;
  logic                 ovf_next;
  // Decision points in half units of the measured reference
  logic [CNT_WIDTH+2:0] zero_lo;
  logic [CNT_WIDTH+2:0] one_lo;
  logic [CNT_WIDTH+2:0] one_hi;
  logic [CNT_WIDTH+2:0] eof_lim;

  // Scale helper: measured unit times halves
  function automatic logic [CNT_WIDTH+2:0] halves(input logic [CNT_WIDTH-1:0] u, input int n);
    halves = (CNT_WIDTH+3)'((u * n) >> 1);
  endfunction

  // Thresholds track the calibrated unit, so reader clock drift is absorbed.
  // Halving truncates, which moves each window by under one clock cycle.
  always_comb begin
    zero_lo = halves(tari_reg, ZERO_LO_HALVES);
    one_lo  = halves(tari_reg, ONE_LO_HALVES);
    one_hi  = halves(tari_reg, ONE_HI_HALVES);
    eof_lim = halves(tari_reg, EOF_HALVES);
  end

  // Interval count, saturating so a dead carrier cannot wrap
  always_comb begin
    prev_next = carrier_in;
    fall      = prev_reg && !carrier_in;
    if (fall) begin
      cnt_next = '0;
    end else if (cnt_reg != '1) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Symbol decoder state machine.
  // The interval ending at a fall is the count plus one, since the count
  // restarts at zero on the cycle the fall is seen.
  // Only falls carry timing; pulse width is ignored so depth and shaping
  // of the pulse cannot skew a decision.
  always_comb begin
    logic [CNT_WIDTH+2:0] iv;
    iv            = (CNT_WIDTH+3)'(cnt_reg) + 1'b1;
    st_next       = st_reg;
    tari_next     = tari_reg;
    fifo_in_valid = 1'b0;
    fifo_in       = '0;
    done_next     = 1'b0;
    err_next      = 1'b0;
    ovf_next      = 1'b0;
    unique case (st_reg)
      FLPC_READY: begin
        // First falling edge opens the start-of-frame
        if (fall) begin
          st_next = FLPC_CAL;
        end
      end
      FLPC_CAL: begin
        if (fall) begin
          // Three measured units give the reference
          tari_next = CNT_WIDTH'(iv / SOF_CAL_UNITS);
          st_next   = FLPC_DATA;
        end else if (iv > (CNT_WIDTH+3)'(SOF_LIMIT)) begin
          // A lone fall never becomes a frame; wait for a fresh one
          st_next = FLPC_READY;
        end
      end
      FLPC_DATA: begin
        if (fall) begin
          // Outside both windows is an invalid code: drop the frame
          if (iv <= zero_lo || iv > one_hi) begin
            st_next  = FLPC_QUIET;
            err_next = 1'b1;
            fifo_in_valid = 1'b1;
            fifo_in.frame_end = 1'b1;
          end else begin
            // A full FIFO loses the bit; the parser learns by overflow
            fifo_in_valid   = 1'b1;
            fifo_in.bit_val = iv > one_lo;
            ovf_next        = !fifo_in_ready;
          end
        end else if (iv > eof_lim) begin
          // Silence over four units: clean end of frame
          st_next           = FLPC_READY;
          done_next         = 1'b1;
          fifo_in_valid     = 1'b1;
          fifo_in.frame_end = 1'b1;
        end
      end
      FLPC_QUIET: begin
        // Falling edges restart the quiet wait by clearing the count
        // The unit stays as calibrated, so the wait matches the frame
        if (!fall && iv > eof_lim) begin
          st_next = FLPC_READY;
        end
      end
    endcase
  end

  // Timing and state registers.
  // The carrier sample resets high so a low line at release reads as a falling edge.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg <= 1'b1;
      cnt_reg  <= '0;
      tari_reg <= CNT_WIDTH'(TARI_CYC);
      st_reg   <= FLPC_READY;
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
      ovf_reg  <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg  <= cnt_next;
      tari_reg <= tari_next;
      st_reg   <= st_next;
      done_reg <= done_next;
      err_reg  <= err_next;
      ovf_reg  <= ovf_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit stream to parser through FIFO, in arrival order (MSB first)
  // ----------------------------------------------------------------
  flpc_fifo #(
    .WIDTH ($bits(flpc_sym_t)),
    .DEPTH (DEPTH)
  ) flpc_fifo_inst (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // Frame-end markers drain silently; data words wait for the parser.
  // Bits already queued before an error are still handed over, so the
  // parser must drop its partial frame when it sees frame_error.
  always_comb begin
    bit_valid = fifo_out_valid && !fifo_out.frame_end;
    bit_data  = fifo_out.bit_val;
    fifo_pop  = fifo_out_valid && (fifo_out.frame_end || bit_ready);
  end

  assign frame_done    = done_reg;
  assign frame_error   = err_reg;
  assign sym_overflow  = ovf_reg;
  assign decoder_ready = st_reg == FLPC_READY;

  // ----------------------------------------------------------------
  // Identifier: constants only, no write path exists
  // ----------------------------------------------------------------
  assign unique_identifier = {ALLOC_PREFIX, MAKER_CODE, PAD_ZERO, SERIAL};
  assign short_tag_id      = {MAKER_CODE, SERIAL};
  // Arbitration replies carry the short form, system query the full one
  assign reply_id = full_id_sel ? unique_identifier : {{ID_PAD_W{1'b0}}, short_tag_id};
endmodule

`default_nettype wire

// file: sim/flpc_codec_assertions.sv
// Concurrent checks on the codec top ports
`timescale 1ns/1ps
`default_nettype none
module flpc_codec_checker import flpc_pkg::*; (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  carrier_in,
  input wire logic                  bit_valid,
  input wire logic                  bit_data,
  input wire logic                  bit_ready,
  input wire logic                  frame_done,
  input wire logic                  frame_error,
  input wire logic                  decoder_ready,
  input wire logic                  full_id_sel,
  input wire logic [UID_W-1:0]      unique_identifier,
  input wire logic [SHORT_ID_W-1:0] short_tag_id,
  input wire logic [UID_W-1:0]      reply_id
);
  // ------
  // Silence counter
  // ------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Limit covers an unfinished start-of-frame too
  localparam int LIM = 8 * TARI_CYC + 16;
  int q_reg;
  int q_next;
  // Saturates so the check holds for the whole silence
  always_comb q_next = !carrier_in ? 0 : (q_reg == LIM ? LIM : q_reg + 1);
  always_ff @(posedge clk_sys) q_reg <= rst ? 0 : q_next;
  sequence s_fall;
    carrier_in ##1 !carrier_in;
  endsequence
  a_fall_busy: assert property (s_fall |-> ##[1:3] !decoder_ready)
    else $error("fall left decoder ready");
  a_quiet_ready: assert property (q_reg == LIM |-> decoder_ready)
    else $error("no return to ready");
  a_done_ready: assert property (frame_done |-> ##[0:1] decoder_ready)
    else $error("done without ready");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("done too long");
  a_err_pulse: assert property (frame_error |=> !frame_error)
    else $error("error too long");
  a_err_quiet: assert property (frame_error |=> (!decoder_ready && !frame_done) [*8])
    else $error("frame not dropped");
  a_hold_bit: assert property (bit_valid && !bit_ready |=> bit_valid && $stable(bit_data))
    else $error("bit lost while stalled");
  a_id_layout: assert property (unique_identifier ==
    {ALLOC_PREFIX, short_tag_id[39:32], PAD_ZERO, short_tag_id[31:0]})
    else $error("identifier layout wrong");
  a_id_fixed: assert property ($stable(unique_identifier) && $stable(short_tag_id))
    else $error("identifier changed");
  a_reply_sel: assert property (reply_id ==
    (full_id_sel ? unique_identifier : {24'h000000, short_tag_id}))
    else $error("reply id wrong");
endmodule
bind flpc_codec flpc_codec_checker flpc_codec_checker_inst (.clk_sys(clk_sys), .rst(rst),
  .carrier_in(carrier_in), .bit_valid(bit_valid), .bit_data(bit_data), .bit_ready(bit_ready),
  .frame_done(frame_done), .frame_error(frame_error), .decoder_ready(decoder_ready),
  .full_id_sel(full_id_sel), .unique_identifier(unique_identifier),
  .short_tag_id(short_tag_id), .reply_id(reply_id));
`default_nettype wire

// file: sim/flpc_reader.sv
// Reader model driving the modulated carrier
`timescale 1ns/1ps
`default_nettype none
module flpc_reader import flpc_pkg::*; #(
  parameter int PW    = 400,  // Nominal low time, half a unit
  parameter int QUIET = 12000 // 300 us of steady carrier
) (
  input wire logic clk_sys,
  output var logic carrier_in
);
  initial carrier_in = 1'b1;
  // One low pulse, then steady carrier until the next fall is due
  task automatic pulse(input int n);
    int pw;
    pw = (n > 2 * PW) ? PW : n / 2;
    carrier_in <= 1'b0;
    repeat (pw) @(posedge clk_sys);
    carrier_in <= 1'b1;
    repeat (n - pw) @(posedge clk_sys);
  endtask
  // Whole frame; a nonzero bad adds one malformed interval
  task automatic send_frame(input logic [31:0] d, input int n, input int bad);
    repeat (QUIET) @(posedge clk_sys);
    pulse(3 * TARI_CYC);
    for (int i = n - 1; i >= 0; i--) begin
      pulse(d[i] ? 2 * TARI_CYC : TARI_CYC);
    end
    if (bad != 0) begin
      pulse(bad);
    end
    pulse(5 * TARI_CYC);
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the pulse interval codec
`timescale 1ns/1ps
`default_nettype none
module tb import flpc_pkg::*;;
  localparam logic [7:0]  MK = 8'h3c;         // Arbitrary maker value
  localparam logic [31:0] SN = 32'h1234_5678; // Arbitrary serial value
  localparam logic [7:0]  ROW_D [2] = '{8'hb1, 8'h06};
  localparam int          ROW_N [2] = '{8, 4};
  logic                  clk_sys, rst, bit_ready, full_id_sel, carrier_in;
  logic                  bit_valid, bit_data, frame_done, frame_error, sym_overflow, decoder_ready;
  logic [UID_W-1:0]      unique_identifier, reply_id;
  logic [SHORT_ID_W-1:0] short_tag_id;
  logic [63:0]           shreg;
  int                    err_count = 0, n_tests = 0, cyc = 0, nbits, done_n, errs_n, ovf_n;
  flpc_codec #(.MAKER_CODE(MK), .SERIAL(SN)) flpc_codec_inst (.clk_sys(clk_sys), .rst(rst),
    .carrier_in(carrier_in), .bit_valid(bit_valid), .bit_data(bit_data), .bit_ready(bit_ready),
    .frame_done(frame_done), .frame_error(frame_error), .sym_overflow(sym_overflow),
    .decoder_ready(decoder_ready), .full_id_sel(full_id_sel), .unique_identifier(unique_identifier),
    .short_tag_id(short_tag_id), .reply_id(reply_id));
  flpc_reader flpc_reader_inst (.clk_sys(clk_sys), .carrier_in(carrier_in));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ------
  // Parser side monitor and hang limit
  // ------
  always @(posedge clk_sys) begin
    cyc++;
    if (bit_valid === 1'b1 && bit_ready) begin
      shreg = {shreg[62:0], bit_data};
      nbits++;
    end
    done_n += (frame_done === 1'b1);
    errs_n += (frame_error === 1'b1);
    ovf_n += (sym_overflow === 1'b1);
    if (cyc == 120000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Clear off the edge so the monitor never races the reset of counts
  task automatic run(input logic [31:0] d, input int n, input int bad);
    @(negedge clk_sys);
    nbits = 0;
    shreg = '0;
    done_n = 0;
    errs_n = 0;
    ovf_n = 0;
    @(posedge clk_sys);
    flpc_reader_inst.send_frame(d, n, bad);
    @(negedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence: reset, identifiers, rows, then stall and bad frame
  initial begin
    rst = 1'b1;
    bit_ready = 1'b0;
    full_id_sel = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(decoder_ready, 1);
    chk(bit_valid, 0);
    chk(reply_id, {ALLOC_PREFIX, MK, PAD_ZERO, SN});
    @(posedge clk_sys) full_id_sel <= 1'b0;
    @(negedge clk_sys);
    chk(reply_id, {24'h000000, MK, SN});
    chk(short_tag_id, {MK, SN});
    chk({ALLOC_PREFIX, short_tag_id[39:32], PAD_ZERO, short_tag_id[31:0]}, unique_identifier);
    $display("test identifiers done");
    @(posedge clk_sys) bit_ready <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      run(ROW_D[r], ROW_N[r], 0);
      chk(nbits, ROW_N[r]);
      chk(shreg, ROW_D[r]);
      chk(done_n, 1);
      chk(decoder_ready, 1);
      $display("test row %0d done", r);
    end
    @(posedge clk_sys) bit_ready <= 1'b0;
    run(32'h0001_0001, 17, 0);
    chk(ovf_n, 1);
    chk(bit_valid, 1);
    @(posedge clk_sys) bit_ready <= 1'b1;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(nbits, FIFO_DEPTH);
    chk(shreg, 64'h8000);
    chk(bit_valid, 0);
    $display("test stall done");
    run(0, 0, 200);
    chk(errs_n, 1);
    chk(done_n, 0);
    chk(decoder_ready, 1);
    $display("test bad interval done");
    give_verdict();
  end
endmodule
`default_nettype wire
